//--- atsq_sequencer.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module atsq_sequencer #(
    parameter int FCNT_W = 16,
    parameter int PER_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Trigger input line 1
    input wire logic trig_line1,
    // Exposure pipeline
    input wire logic frame_ready,
    output logic frame_start,
    output logic [FCNT_W-1:0] frame_index,
    // Status levels
    output logic wait_acq,
    output logic wait_frm
);
    if (FCNT_W < 1 || FCNT_W > 16) begin : g_fcnt_chk
        $error("FCNT_W must be 1 to 16");
    end
    if (PER_W < 2 || PER_W > 32) begin : g_per_chk
        $error("PER_W must be 2 to 32");
    end

    // Configuration
    logic [atsq_pkg::CTRL_W-1:0] ctrl_reg;
    logic [FCNT_W-1:0] frame_count_reg;
    logic [PER_W-1:0] rate_period_reg;
    logic soft_acq_reg;
    logic discard_reg;
    logic [31:0] frames_total_reg;

    // Sequencer
    atsq_pkg::atsq_state_e state_reg;
    atsq_pkg::atsq_state_e state_next;
    logic [FCNT_W-1:0] burst_cnt_reg;
    logic pace_pend_reg;
    logic pace_pend_next;
    logic frame_start_reg;
    logic [FCNT_W-1:0] frame_index_reg;

    // Bus decode
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] rd_mux;
    logic [31:0] prdata_reg;
    logic wr_ctrl;
    logic wr_fcnt;
    logic wr_rate;
    logic wr_cmd;
    logic wr_status;

    // Trigger paths
    logic acq_edge;
    logic frm_edge;
    logic acq_event;
    logic frm_req;
    logic frm_take;
    logic frm_discard;
    logic pace_tick;
    logic enter_frm;
    logic burst_last;

    logic acq_run;
    logic acq_trig_on;
    logic acq_src_sw;
    logic frm_trig_on;
    logic rate_on;

    assign acq_run = ctrl_reg[atsq_pkg::CTRL_ACQ_RUN];
    assign acq_trig_on = ctrl_reg[atsq_pkg::CTRL_ACQ_TRIG_ON];
    assign acq_src_sw = ctrl_reg[atsq_pkg::CTRL_ACQ_SRC_SW];
    assign frm_trig_on = ctrl_reg[atsq_pkg::CTRL_FRM_TRIG_ON];
    assign rate_on = ctrl_reg[atsq_pkg::CTRL_RATE_ON];

    // APB: zero wait states, error on unmapped offsets
    assign wr_en = psel & penable & pwrite & addr_ok;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_reg;

    // Per-register write strobes; CTRL and CMD also need the low byte lane
    assign wr_ctrl = wr_en && paddr == atsq_pkg::OFS_CTRL && pstrb[0];
    assign wr_fcnt = wr_en && paddr == atsq_pkg::OFS_FRAME_COUNT;
    assign wr_rate = wr_en && paddr == atsq_pkg::OFS_RATE_PERIOD;
    assign wr_cmd = wr_en && paddr == atsq_pkg::OFS_CMD && pstrb[0];
    assign wr_status = wr_en && paddr == atsq_pkg::OFS_STATUS;

    always_comb begin
        case (paddr)
            atsq_pkg::OFS_CTRL,
            atsq_pkg::OFS_FRAME_COUNT,
            atsq_pkg::OFS_RATE_PERIOD,
            atsq_pkg::OFS_CMD,
            atsq_pkg::OFS_STATUS,
            atsq_pkg::OFS_FRAMES_TOTAL: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            atsq_pkg::OFS_CTRL: begin
                rd_mux[atsq_pkg::CTRL_W-1:0] = ctrl_reg;
            end
            atsq_pkg::OFS_FRAME_COUNT: begin
                rd_mux[FCNT_W-1:0] = frame_count_reg;
            end
            atsq_pkg::OFS_RATE_PERIOD: begin
                rd_mux[PER_W-1:0] = rate_period_reg;
            end
            atsq_pkg::OFS_STATUS: begin
                rd_mux[atsq_pkg::STAT_STATE_LSB +: 3] = state_reg;
                rd_mux[atsq_pkg::STAT_DISCARD] = discard_reg;
                rd_mux[atsq_pkg::STAT_BURST_LSB +: FCNT_W] = burst_cnt_reg;
            end
            atsq_pkg::OFS_FRAMES_TOTAL: begin
                rd_mux = frames_total_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= atsq_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata[atsq_pkg::CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_count_reg <= atsq_pkg::FRAME_COUNT_RESET[FCNT_W-1:0];
        end else if (wr_fcnt) begin
            frame_count_reg <= pwdata[FCNT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_period_reg <= atsq_pkg::RATE_PERIOD_RESET[PER_W-1:0];
        end else if (wr_rate) begin
            rate_period_reg <= pwdata[PER_W-1:0];
        end
    end

    // Software acquisition command, a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_acq_reg <= 1'b0;
        end else begin
            soft_acq_reg <= wr_cmd && pwdata[atsq_pkg::CMD_SOFT_ACQ];
        end
    end

    // Discard flag: a new discard wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            discard_reg <= 1'b0;
        end else if (frm_discard) begin
            discard_reg <= 1'b1;
        end else if (wr_status && pwdata[atsq_pkg::STAT_DISCARD]) begin
            discard_reg <= 1'b0;
        end
    end

    // Edge qualification on line 1
    atsq_edge u_acq_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(trig_line1),
        .falling_sel(ctrl_reg[atsq_pkg::CTRL_ACQ_FALL]),
        .edge_pulse(acq_edge)
    );

    atsq_edge u_frm_edge (
        .pclk(pclk),
        .presetn(presetn),
        .level_in(trig_line1),
        .falling_sel(ctrl_reg[atsq_pkg::CTRL_FRM_FALL]),
        .edge_pulse(frm_edge)
    );

    // Internal frame pacing restarts with every burst
    atsq_pacer #(
        .PER_W(PER_W)
    ) u_pacer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(enter_frm),
        .period(rate_period_reg),
        .tick(pace_tick)
    );

    // Software command and line edge are interchangeable sources
    assign acq_event = acq_src_sw ? soft_acq_reg : acq_edge;

    // Pending pacing tick waits for the pipeline; a tick taken at once must not stay pending
    always_comb begin
        if (state_reg != atsq_pkg::ST_WAIT_FRM) begin
            pace_pend_next = 1'b0;
        end else if (pace_tick) begin
            pace_pend_next = pace_pend_reg | ~frm_take;
        end else if (frm_take) begin
            pace_pend_next = 1'b0;
        end else begin
            pace_pend_next = pace_pend_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace_pend_reg <= 1'b0;
        end else begin
            pace_pend_reg <= pace_pend_next;
        end
    end

    always_comb begin
        if (frm_trig_on) begin
            frm_req = frm_edge;
        end else if (rate_on) begin
            frm_req = pace_pend_reg | pace_tick;
        end else begin
            frm_req = 1'b1;
        end
    end

    // Frames start only in the waiting-frame state and only when the pipeline accepts
    assign frm_take = frm_req && frame_ready && state_reg == atsq_pkg::ST_WAIT_FRM;
    assign frm_discard = frm_trig_on && frm_edge && !frm_take;

    // Zero or one frames per burst both end the burst after one frame
    assign burst_last = (burst_cnt_reg + {{(FCNT_W-1){1'b0}}, 1'b1}) >= frame_count_reg;
    assign enter_frm = state_reg != atsq_pkg::ST_WAIT_FRM && state_next == atsq_pkg::ST_WAIT_FRM;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            atsq_pkg::ST_IDLE: begin
                if (acq_run) begin
                    state_next = atsq_pkg::ST_WAIT_ACQ;
                end
            end
            atsq_pkg::ST_WAIT_ACQ: begin
                if (!acq_run) begin
                    state_next = atsq_pkg::ST_IDLE;
                end else if (!acq_trig_on) begin
                    state_next = atsq_pkg::ST_WAIT_FRM;
                end else if (acq_event) begin
                    state_next = atsq_pkg::ST_WAIT_FRM;
                end
            end
            atsq_pkg::ST_WAIT_FRM: begin
                if (!acq_run) begin
                    state_next = atsq_pkg::ST_IDLE;
                end else if (frm_take && burst_last) begin
                    state_next = atsq_pkg::ST_WAIT_ACQ;
                end
            end
            default: begin
                state_next = atsq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= atsq_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_cnt_reg <= '0;
        end else if (enter_frm) begin
            burst_cnt_reg <= '0;
        end else if (frm_take) begin
            burst_cnt_reg <= burst_cnt_reg + {{(FCNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Frame start pulse with its index inside the burst
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_start_reg <= 1'b0;
        end else begin
            frame_start_reg <= frm_take;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_index_reg <= '0;
        end else if (frm_take) begin
            frame_index_reg <= burst_cnt_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_total_reg <= 32'h0000_0000;
        end else if (frm_take) begin
            frames_total_reg <= frames_total_reg + 32'h0000_0001;
        end
    end

    assign frame_start = frame_start_reg;
    assign frame_index = frame_index_reg;
    assign wait_acq = state_reg == atsq_pkg::ST_WAIT_ACQ;
    assign wait_frm = state_reg == atsq_pkg::ST_WAIT_FRM;

endmodule : atsq_sequencer
`default_nettype wire

//--- atsq_pkg.sv
// Contract
// - With acquisition trigger on, stay waiting; outside party supplies trigger before frames.
// - Acquisition trigger may come from input line 1 with selectable edge polarity.
// - Qualifying acquisition edge moves waiting-acquisition to waiting-frame state.
// - Count burst frames; on reaching frames-per-burst return to waiting-acquisition.
// - After a burst no frames until a fresh acquisition trigger arrives.
// - Frame trigger off: frame starts made internally, paced by the rate setting.
// - Rate setting disabled: internal frame starts at the highest rate allowed.
// - Software command acts exactly like a qualifying acquisition edge.
// - Frame trigger on with line 1: each qualifying edge starts one frame.
// - Frame requests act only in waiting-frame state; others are discarded.
// - Continuous mode repeats wait, burst, return indefinitely without reconfiguration.
// - Acquisition trigger off: acquisition triggers are generated internally.
package atsq_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FRAME_COUNT = 8'h04;
    localparam logic [7:0] OFS_RATE_PERIOD = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_FRAMES_TOTAL = 8'h14;

    // Control field positions
    localparam int CTRL_ACQ_RUN = 0;
    localparam int CTRL_ACQ_TRIG_ON = 1;
    localparam int CTRL_ACQ_SRC_SW = 2;
    localparam int CTRL_ACQ_FALL = 3;
    localparam int CTRL_FRM_TRIG_ON = 4;
    localparam int CTRL_FRM_FALL = 5;
    localparam int CTRL_RATE_ON = 6;
    localparam int CTRL_W = 7;

    // Command and status field positions
    localparam int CMD_SOFT_ACQ = 0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_DISCARD = 3;
    localparam int STAT_BURST_LSB = 16;

    // Values after reset
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [15:0] FRAME_COUNT_RESET = 16'h0001;
    localparam logic [31:0] RATE_PERIOD_RESET = 32'h0000_03e8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT_ACQ = 3'b010,
        ST_WAIT_FRM = 3'b100
    } atsq_state_e;

endpackage : atsq_pkg

//--- atsq_edge.sv
`timescale 1ns/10ps
`default_nettype none
module atsq_edge (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Level in, edge select, event out
    input wire logic level_in,
    input wire logic falling_sel,
    output logic edge_pulse
);
    logic prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= level_in;
        end
    end

    // One-cycle event on the selected transition
    always_comb begin
        if (falling_sel) begin
            edge_pulse = prev_reg & ~level_in;
        end else begin
            edge_pulse = ~prev_reg & level_in;
        end
    end
endmodule : atsq_edge
`default_nettype wire

//--- atsq_pacer.sv
`timescale 1ns/10ps
`default_nettype none
module atsq_pacer #(
    parameter int PER_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic restart,
    input wire logic [PER_W-1:0] period,
    // One-cycle enable every period cycles
    output logic tick
);
    logic [PER_W-1:0] cnt_reg;

    // Period 0 or 1 ticks every cycle
    assign tick = ~restart && (cnt_reg <= {{(PER_W-1){1'b0}}, 1'b1});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (restart || tick) begin
            cnt_reg <= period;
        end else begin
            cnt_reg <= cnt_reg - {{(PER_W-1){1'b0}}, 1'b1};
        end
    end
endmodule : atsq_pacer
`default_nettype wire

//--- atsq_sva.sv
`timescale 1ns/10ps
`default_nettype none
module atsq_sva #(
    parameter int FCNT_W = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pipeline side
    input wire logic frame_ready,
    input wire logic frame_start,
    input wire logic [FCNT_W-1:0] frame_index,
    // Status levels
    input wire logic wait_acq,
    input wire logic wait_frm
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_excl;
        !(wait_acq && wait_frm);
    endproperty
    a_excl: assert property (p_excl) else $error("both wait states high");
    property p_enter;
        $rose(wait_frm) |-> $past(wait_acq);
    endproperty
    a_enter: assert property (p_enter) else $error("frame wait entered not from acquisition wait");
    property p_done;
        $fell(wait_frm) && wait_acq |-> frame_start;
    endproperty
    a_done: assert property (p_done) else $error("burst ended without a last frame");
    property p_count;
        frame_start && $past(frame_start) |-> frame_index == $past(frame_index) + 1'b1;
    endproperty
    a_count: assert property (p_count) else $error("frame index did not step");
    property p_hold;
        !frame_start |-> $stable(frame_index);
    endproperty
    a_hold: assert property (p_hold) else $error("frame index moved without a frame");
    property p_quiet;
        wait_acq && $past(wait_acq) |-> !frame_start;
    endproperty
    a_quiet: assert property (p_quiet) else $error("frame while waiting for acquisition");
    property p_only;
        frame_start |-> $past(wait_frm);
    endproperty
    a_only: assert property (p_only) else $error("frame outside frame wait");
    property p_ready;
        frame_start |-> $past(frame_ready);
    endproperty
    a_ready: assert property (p_ready) else $error("frame while pipeline busy");
    property p_first;
        frame_start && $past(wait_acq, 2) |-> frame_index == '0;
    endproperty
    a_first: assert property (p_first) else $error("burst did not count from zero");
endmodule : atsq_sva
bind atsq_sequencer atsq_sva #(.FCNT_W(FCNT_W)) u_sva (.pclk(pclk), .presetn(presetn), .frame_ready(frame_ready),
    .frame_start(frame_start), .frame_index(frame_index), .wait_acq(wait_acq), .wait_frm(wait_frm));
`default_nettype wire

//--- atsq_trig_src.sv
`timescale 1ns/10ps
`default_nettype none
module atsq_trig_src (
    // Clock
    input wire logic pclk,
    // Trigger line toward the device
    output logic trig_line1
);
    initial trig_line1 = 1'b0;
    // One pulse gives one edge of each polarity; width sets slow or prompt
    task automatic pulse(input int hi);
        trig_line1 <= 1'b1;
        repeat (hi) @(posedge pclk);
        trig_line1 <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : pulse
endmodule : atsq_trig_src
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, trig_line1, frame_ready, frame_start, wait_acq, wait_frm;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [15:0] frame_index;
    int err_count = 0;
    int num_checks = 0;
    int frames = 0;
    int gap = 0;
    int min_gap = 100;
    int cyc = 0;
    int f0;

    always #2.5 pclk = ~pclk;

    atsq_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_line1(trig_line1), .frame_ready(frame_ready), .frame_start(frame_start),
        .frame_index(frame_index), .wait_acq(wait_acq), .wait_frm(wait_frm));
    atsq_trig_src src (.pclk(pclk), .trig_line1(trig_line1));

    // Frame counting and spacing between frame starts
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        gap <= (frame_start === 1'b1) ? 1 : gap + 1;
        if (frame_start === 1'b1) begin
            frames <= frames + 1;
            if (gap < min_gap) min_gap <= gap;
        end
        if (cyc == 4000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, g, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
    endtask : rd

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    initial begin
        logic [31:0] r;
        logic e;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        frame_ready = 1'b1;
        wt(8);
        presetn <= 1'b1;
        wt(1);
        rd(atsq_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
        rd(atsq_pkg::OFS_FRAME_COUNT, 32'hffffffff, 32'h1);
        rd(atsq_pkg::OFS_RATE_PERIOD, 32'hffffffff, 32'h3e8);
        rd(atsq_pkg::OFS_STATUS, 32'h0000000f, 32'h1);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk({r[31:1], e}, 32'h1);
        wr(atsq_pkg::OFS_FRAMES_TOTAL, 32'h5);
        rd(atsq_pkg::OFS_FRAMES_TOTAL, 32'hffffffff, 32'h0);
        // Line-triggered burst of three, free-running frames
        wr(atsq_pkg::OFS_FRAME_COUNT, 32'h3);
        wr(atsq_pkg::OFS_CTRL, 32'h03);
        rd(atsq_pkg::OFS_STATUS, 32'h7, 32'h2);
        wt(10);
        chk(frames, 0);
        chk({30'h0, wait_frm, wait_acq}, 32'h1);
        src.pulse(2);
        wt(15);
        chk(frames, 3);
        chk(min_gap, 1);
        chk({16'h0, frame_index}, 32'h2);
        rd(atsq_pkg::OFS_STATUS, 32'h7, 32'h2);
        wt(20);
        chk(frames, 3);
        wr(atsq_pkg::OFS_CTRL, 32'h0b);
        src.pulse(2);
        wt(15);
        chk(frames, 6);
        rd(atsq_pkg::OFS_FRAMES_TOTAL, 32'hffffffff, 32'h6);
        // Paced frames, four cycles apart
        wr(atsq_pkg::OFS_RATE_PERIOD, 32'h4);
        wr(atsq_pkg::OFS_CTRL, 32'h43);
        min_gap = 100;
        src.pulse(2);
        wt(40);
        chk(frames, 9);
        chk(min_gap, 4);
        // Software acquisition trigger, line frame triggers
        wr(atsq_pkg::OFS_CTRL, 32'h17);
        src.pulse(2);
        chk(frames, 9);
        rd(atsq_pkg::OFS_STATUS, 32'hf, 32'ha);
        wr(atsq_pkg::OFS_STATUS, 32'h8);
        rd(atsq_pkg::OFS_STATUS, 32'hf, 32'h2);
        wr(atsq_pkg::OFS_CMD, 32'h1);
        wt(4);
        rd(atsq_pkg::OFS_STATUS, 32'h7, 32'h4);
        chk({30'h0, wait_frm, wait_acq}, 32'h2);
        repeat (4) src.pulse(2);
        chk(frames, 12);
        rd(atsq_pkg::OFS_STATUS, 32'hf, 32'ha);
        // Falling frame edges after a software acquisition trigger
        wr(atsq_pkg::OFS_STATUS, 32'h8);
        wr(atsq_pkg::OFS_CTRL, 32'h37);
        wr(atsq_pkg::OFS_CMD, 32'h1);
        wt(4);
        repeat (3) src.pulse(2);
        chk(frames, 15);
        rd(atsq_pkg::OFS_STATUS, 32'hf, 32'h2);
        // Free run with internal acquisition triggers, then a stalled pipeline
        wr(atsq_pkg::OFS_STATUS, 32'h8);
        wr(atsq_pkg::OFS_FRAME_COUNT, 32'h2);
        wr(atsq_pkg::OFS_CTRL, 32'h01);
        f0 = frames;
        wt(30);
        chk(32'(frames - f0 >= 15), 32'h1);
        frame_ready <= 1'b0;
        wt(2);
        f0 = frames;
        wt(20);
        chk(frames, f0);
        frame_ready <= 1'b1;
        wt(10);
        chk(32'(frames - f0 >= 5), 32'h1);
        // A control write without the low byte lane is ignored
        pstrb <= 4'h0;
        wr(atsq_pkg::OFS_CTRL, 32'h0);
        pstrb <= 4'hf;
        rd(atsq_pkg::OFS_CTRL, 32'hffffffff, 32'h1);
        wr(atsq_pkg::OFS_CTRL, 32'h0);
        rd(atsq_pkg::OFS_STATUS, 32'h7, 32'h1);
        test_done();
    end
endmodule : testbench
`default_nettype wire
